// *** shared/adio_pkg.sv ***
// constants, register map and encodings for the auxiliary digital i/o block
package adio_pkg;

  // ------------------------------------------------------------------
  // clock and timing
  // ------------------------------------------------------------------
  localparam int CLK_HZ = 25000000;
  localparam int MS_PER_S = 1000;
  localparam int CYC_PER_MS = CLK_HZ / MS_PER_S;
  localparam int STROBE_WIDTH_NS = 1000;
  localparam int CLK_PERIOD_NS = 40;
  localparam int STROBE_CYC = (STROBE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FILT_MAX_MS = 10000000;

  // ------------------------------------------------------------------
  // widths
  // ------------------------------------------------------------------
  localparam int NUM_DOUT = 4;
  localparam int NUM_DIN = 3;
  localparam int FUNC_W = 4;
  localparam int FILT_W = 24;
  localparam int PRE_W = 16;
  localparam int STB_W = 6;

  // ------------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------------
  localparam logic [7:0] OFS_DOUT_FUNC = 8'h00;
  localparam logic [7:0] OFS_DOUT_INV = 8'h04;
  localparam logic [7:0] OFS_FILT1 = 8'h08;
  localparam logic [7:0] OFS_FILT2 = 8'h0c;
  localparam logic [7:0] OFS_FILT3 = 8'h10;
  localparam logic [7:0] OFS_STROBE = 8'h14;
  localparam logic [7:0] OFS_TRIG = 8'h18;
  localparam logic [7:0] OFS_REMOTE = 8'h1c;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  localparam logic [7:0] OFS_EDGES = 8'h24;

  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int STB_TRANS_BIT = 0;
  localparam int STB_RELAY_BIT = 1;
  localparam int STB_PARAM_BIT = 2;
  localparam int TRIG_EN_BIT = 0;
  localparam int TRIG_IMM_BIT = 1;
  localparam int TRIG_AUTO_BIT = 2;
  localparam int ST_DIN_LSB = 0;
  localparam int ST_DOUT_LSB = 4;
  localparam int ST_RELAY_BIT = 8;
  localparam int ST_CONTACT_BIT = 9;
  localparam int ST_STROBE_BIT = 10;
  localparam int EDGE_FALL_LSB = 4;

  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam logic [15:0] RST_DOUT_FUNC = 16'h0000;
  localparam logic [3:0] RST_DOUT_INV = 4'h0;
  localparam logic [23:0] RST_FILT = 24'h000000;
  localparam logic [2:0] RST_STROBE = 3'h0;
  localparam logic [2:0] RST_TRIG = 3'h0;

  // ------------------------------------------------------------------
  // encodings
  // ------------------------------------------------------------------
  typedef enum logic [3:0] {
    FN_LOW, FN_HIGH, FN_FAULT, FN_PHASE, FN_RELAY,
    FN_PROGRAM, FN_REMOTE, FN_TRANSIENT, FN_COUPLING
  } adio_func_t;

  typedef enum logic [1:0] {
    RC_DISABLED, RC_INHIBIT, RC_ENABLE
  } adio_remote_t;

endpackage

// *** logic/adio_aux_io.sv ***
// auxiliary digital i/o: outputs, filtered inputs, strobe, trigger and relay gate
`timescale 1ns/1ns

// Notes on behaviour
// - four digital outputs, each fed by a per-channel selectable source
// - fault source: 1 while a fault is present, else 0
// - phase source: 1 for single-phase, 0 for split or three-phase
// - relay source: 1 while the output relay is closed
// - program source: 1 while a stored program runs, 0 in manual
// - remote source: 1 under remote control, 0 under local
// - transient source: 1 while running, paused or stepping; 0 when stopped
// - coupling source: 1 when transformer coupled, 0 when direct
// - each output has its own invert bit that reverses the level
// - channels three and four: a logical 1 turns the fet on, pin low
// - three inputs; a rising edge raises that channel's rising-edge event
// - a falling edge raises that channel's falling-edge event
// - each input has a filter length of 0 to 10,000,000 ms
// - strobe on transient start when that source is enabled
// - strobe when the output relay closes when that source is enabled
// - strobe on any setting change when that source is enabled
// - remote disabled: the contact input does not touch the relay
// - inhibit mode: relay closes only while the contact is closed
// - enable mode: contact or front panel may close the relay
// - auto-start on: a trigger alone starts the transient
// - immediate on: a trigger start skips the phase update point
module adio_aux_io #(
  parameter int CYC_PER_MS = adio_pkg::CYC_PER_MS
) (
  input wire logic core_clk,
  input wire logic nrst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // instrument state, same clock
  input wire logic faultActive,
  input wire logic singlePhase,
  input wire logic programActive,
  input wire logic remoteActive,
  input wire logic transientActive,
  input wire logic couplingModeFlag,
  input wire logic panelRelayReq,
  input wire logic runRequest,
  input wire logic phaseUpdatePoint,
  input wire logic settingChanged,
  // pins
  input wire logic [2:0] digitalIn,
  input wire logic extTrigger,
  input wire logic contactClosed,
  output logic [1:0] digitalOutTtl,
  output logic openDrainOutputThreeOut,
  output logic openDrainOutputThreeOe,
  output logic openDrainOutputFourOut,
  output logic openDrainOutputFourOe,
  output logic strobeOut,
  // towards firmware and power stage
  output logic [2:0] riseEvent,
  output logic [2:0] fallEvent,
  output logic relayClose,
  output logic transientStart
);

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  logic [15:0] doutFunc_reg;
  logic [3:0] polarityInvert_reg;
  logic [23:0] filt_reg [3];
  logic [2:0] strobeEn_reg;
  logic [2:0] trigCfg_reg;
  logic [1:0] remoteMode_reg;
  logic [5:0] edgeFlags_reg;
  logic [3:0] dout_reg;
  logic [2:0] dinLevel_reg;
  logic relay_reg;
  logic [31:0] prdata_reg;

  logic apbWrite;
  logic apbSetup;
  logic addrHit;
  logic [31:0] rdMux;
  logic [5:0] edgeSet;
  logic contactSync;

  assign apbWrite = psel & penable & pwrite;
  assign apbSetup = psel & ~penable;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addrHit;
  assign prdata = prdata_reg;

  always_comb begin
    addrHit = 1'b1;
    rdMux = 32'h00000000;
    case (paddr)
      adio_pkg::OFS_DOUT_FUNC: rdMux = {16'h0000, doutFunc_reg};
      adio_pkg::OFS_DOUT_INV: rdMux = {28'h0000000, polarityInvert_reg};
      adio_pkg::OFS_FILT1: rdMux = {8'h00, filt_reg[0]};
      adio_pkg::OFS_FILT2: rdMux = {8'h00, filt_reg[1]};
      adio_pkg::OFS_FILT3: rdMux = {8'h00, filt_reg[2]};
      adio_pkg::OFS_STROBE: rdMux = {29'h00000000, strobeEn_reg};
      adio_pkg::OFS_TRIG: rdMux = {29'h00000000, trigCfg_reg};
      adio_pkg::OFS_REMOTE: rdMux = {30'h00000000, remoteMode_reg};
      adio_pkg::OFS_STATUS: begin
        rdMux[adio_pkg::ST_DIN_LSB +: adio_pkg::NUM_DIN] = dinLevel_reg;
        rdMux[adio_pkg::ST_DOUT_LSB +: adio_pkg::NUM_DOUT] = dout_reg;
        rdMux[adio_pkg::ST_RELAY_BIT] = relay_reg;
        rdMux[adio_pkg::ST_CONTACT_BIT] = contactSync;
        rdMux[adio_pkg::ST_STROBE_BIT] = strobeOut;
      end
      adio_pkg::OFS_EDGES: begin
        rdMux[2:0] = edgeFlags_reg[2:0];
        rdMux[adio_pkg::EDGE_FALL_LSB +: adio_pkg::NUM_DIN] = edgeFlags_reg[5:3];
      end
      default: addrHit = 1'b0;
    endcase
  end

  // read data captured in the setup cycle so it comes from a flop
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      prdata_reg <= 32'h00000000;
    end else if (apbSetup && !pwrite) begin
      prdata_reg <= rdMux;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      doutFunc_reg <= adio_pkg::RST_DOUT_FUNC;
      polarityInvert_reg <= adio_pkg::RST_DOUT_INV;
      filt_reg[0] <= adio_pkg::RST_FILT;
      filt_reg[1] <= adio_pkg::RST_FILT;
      filt_reg[2] <= adio_pkg::RST_FILT;
      strobeEn_reg <= adio_pkg::RST_STROBE;
      trigCfg_reg <= adio_pkg::RST_TRIG;
      remoteMode_reg <= adio_pkg::RC_DISABLED;
    end else if (apbWrite) begin
      case (paddr)
        adio_pkg::OFS_DOUT_FUNC: doutFunc_reg <= pwdata[15:0];
        adio_pkg::OFS_DOUT_INV: polarityInvert_reg <= pwdata[3:0];
        // lengths above the documented maximum are clamped
        adio_pkg::OFS_FILT1: filt_reg[0] <= filtClamp(pwdata[23:0]);
        adio_pkg::OFS_FILT2: filt_reg[1] <= filtClamp(pwdata[23:0]);
        adio_pkg::OFS_FILT3: filt_reg[2] <= filtClamp(pwdata[23:0]);
        adio_pkg::OFS_STROBE: strobeEn_reg <= pwdata[2:0];
        adio_pkg::OFS_TRIG: trigCfg_reg <= pwdata[2:0];
        adio_pkg::OFS_REMOTE: remoteMode_reg <= pwdata[1:0];
        default: begin
        end
      endcase
    end
  end

  function automatic logic [23:0] filtClamp(input logic [23:0] v);
    logic [23:0] lim;
    lim = 24'(adio_pkg::FILT_MAX_MS);
    filtClamp = (v > lim) ? lim : v;
  endfunction

  // ------------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------------
  logic [2:0] dinMeta_reg;
  logic [2:0] dinSync_reg;
  logic trigMeta_reg;
  logic contactMeta_reg;
  logic contactSync_reg;
  logic trigSync_reg;
  logic trigSync;
  logic trigPrev_reg;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      dinMeta_reg <= 3'h0;
      dinSync_reg <= 3'h0;
      trigMeta_reg <= 1'b0;
      contactMeta_reg <= 1'b0;
      contactSync_reg <= 1'b0;
      trigSync_reg <= 1'b0;
      trigPrev_reg <= 1'b0;
    end else begin
      dinMeta_reg <= digitalIn;
      dinSync_reg <= dinMeta_reg;
      trigMeta_reg <= extTrigger;
      trigSync_reg <= trigMeta_reg;
      contactMeta_reg <= contactClosed;
      contactSync_reg <= contactMeta_reg;
      trigPrev_reg <= trigSync;
    end
  end

  assign contactSync = contactSync_reg;
  assign trigSync = trigSync_reg;

  // ------------------------------------------------------------------
  // input debounce and edge events
  // ------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < adio_pkg::NUM_DIN; gi++) begin : gDin
      logic [adio_pkg::PRE_W-1:0] preCnt_reg;
      logic [adio_pkg::FILT_W-1:0] msCnt_reg;
      logic differs;
      logic stableLongEnough;
      assign differs = dinSync_reg[gi] != dinLevel_reg[gi];
      assign stableLongEnough = msCnt_reg >= filt_reg[gi];

      // any bounce back to the old level restarts the wait
      always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
          preCnt_reg <= '0;
          msCnt_reg <= '0;
          dinLevel_reg[gi] <= 1'b0;
        end else if (!differs || stableLongEnough) begin
          preCnt_reg <= '0;
          msCnt_reg <= '0;
          if (differs) begin
            dinLevel_reg[gi] <= dinSync_reg[gi];
          end
        end else if (preCnt_reg == adio_pkg::PRE_W'(CYC_PER_MS - 1)) begin
          preCnt_reg <= '0;
          msCnt_reg <= msCnt_reg + 1'b1;
        end else begin
          preCnt_reg <= preCnt_reg + 1'b1;
        end
      end

      always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
          riseEvent[gi] <= 1'b0;
          fallEvent[gi] <= 1'b0;
        end else begin
          riseEvent[gi] <= differs & stableLongEnough & dinSync_reg[gi];
          fallEvent[gi] <= differs & stableLongEnough & ~dinSync_reg[gi];
        end
      end
      assign edgeSet[gi] = riseEvent[gi];
      assign edgeSet[gi + adio_pkg::NUM_DIN] = fallEvent[gi];
    end
  endgenerate

  // sticky edge flags, write one to clear; a new edge beats the clear
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      edgeFlags_reg <= 6'h00;
    end else if (apbWrite && paddr == adio_pkg::OFS_EDGES) begin
      edgeFlags_reg <= (edgeFlags_reg & ~{pwdata[6:4], pwdata[2:0]}) | edgeSet;
    end else begin
      edgeFlags_reg <= edgeFlags_reg | edgeSet;
    end
  end

  // ------------------------------------------------------------------
  // output relay gate
  // ------------------------------------------------------------------
  logic relayNext;
  always_comb begin
    case (adio_pkg::adio_remote_t'(remoteMode_reg))
      adio_pkg::RC_DISABLED: relayNext = panelRelayReq;
      adio_pkg::RC_INHIBIT: relayNext = panelRelayReq & contactSync;
      adio_pkg::RC_ENABLE: relayNext = panelRelayReq | contactSync;
      default: relayNext = panelRelayReq;
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      relay_reg <= 1'b0;
    end else begin
      relay_reg <= relayNext;
    end
  end
  assign relayClose = relay_reg;

  // ------------------------------------------------------------------
  // trigger and transient start
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {TS_IDLE, TS_ARMED, TS_WAIT_PHASE} adio_trig_t;
  adio_trig_t trigState_reg;
  logic trigEdge;
  logic startPulse_reg;
  assign trigEdge = trigSync & ~trigPrev_reg & trigCfg_reg[adio_pkg::TRIG_EN_BIT];

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      trigState_reg <= TS_IDLE;
      startPulse_reg <= 1'b0;
    end else begin
      startPulse_reg <= 1'b0;
      case (trigState_reg)
        TS_IDLE: begin
          if (!trigCfg_reg[adio_pkg::TRIG_EN_BIT] && runRequest) begin
            trigState_reg <= TS_WAIT_PHASE;
          end else if (trigEdge && trigCfg_reg[adio_pkg::TRIG_AUTO_BIT]) begin
            if (trigCfg_reg[adio_pkg::TRIG_IMM_BIT]) begin
              startPulse_reg <= 1'b1;
            end else begin
              trigState_reg <= TS_WAIT_PHASE;
            end
          end else if (runRequest) begin
            trigState_reg <= TS_ARMED;
          end
        end
        TS_ARMED: begin
          if (!trigCfg_reg[adio_pkg::TRIG_EN_BIT]) begin
            trigState_reg <= TS_WAIT_PHASE;
          end else if (trigEdge && trigCfg_reg[adio_pkg::TRIG_IMM_BIT]) begin
            startPulse_reg <= 1'b1;
            trigState_reg <= TS_IDLE;
          end else if (trigEdge) begin
            trigState_reg <= TS_WAIT_PHASE;
          end
        end
        TS_WAIT_PHASE: begin
          if (phaseUpdatePoint) begin
            startPulse_reg <= 1'b1;
            trigState_reg <= TS_IDLE;
          end
        end
        default: trigState_reg <= TS_IDLE;
      endcase
    end
  end
  assign transientStart = startPulse_reg;

  // ------------------------------------------------------------------
  // strobe
  // ------------------------------------------------------------------
  logic relayPrev_reg;
  logic strobeEvent;
  logic [adio_pkg::STB_W-1:0] strobeCnt_reg;
  assign strobeEvent = (strobeEn_reg[adio_pkg::STB_TRANS_BIT] & startPulse_reg)
    | (strobeEn_reg[adio_pkg::STB_RELAY_BIT] & relay_reg & ~relayPrev_reg)
    | (strobeEn_reg[adio_pkg::STB_PARAM_BIT] & (settingChanged | apbWrite));

  // an event during a pulse restarts it rather than adding a second one
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      relayPrev_reg <= 1'b0;
      strobeCnt_reg <= '0;
      strobeOut <= 1'b0;
    end else begin
      relayPrev_reg <= relay_reg;
      if (strobeEvent) begin
        strobeCnt_reg <= adio_pkg::STB_W'(adio_pkg::STROBE_CYC - 1);
        strobeOut <= 1'b1;
      end else if (strobeCnt_reg != '0) begin
        strobeCnt_reg <= strobeCnt_reg - 1'b1;
      end else begin
        strobeOut <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // digital outputs
  // ------------------------------------------------------------------
  generate
    for (gi = 0; gi < adio_pkg::NUM_DOUT; gi++) begin : gDout
      logic srcLevel;
      always_comb begin
        case (adio_pkg::adio_func_t'(doutFunc_reg[gi*adio_pkg::FUNC_W +: adio_pkg::FUNC_W]))
          adio_pkg::FN_LOW: srcLevel = 1'b0;
          adio_pkg::FN_HIGH: srcLevel = 1'b1;
          adio_pkg::FN_FAULT: srcLevel = faultActive;
          adio_pkg::FN_PHASE: srcLevel = singlePhase;
          adio_pkg::FN_RELAY: srcLevel = relay_reg;
          adio_pkg::FN_PROGRAM: srcLevel = programActive;
          adio_pkg::FN_REMOTE: srcLevel = remoteActive;
          adio_pkg::FN_TRANSIENT: srcLevel = transientActive;
          adio_pkg::FN_COUPLING: srcLevel = couplingModeFlag;
          default: srcLevel = 1'b0;
        endcase
      end
      always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
          dout_reg[gi] <= 1'b0;
        end else begin
          dout_reg[gi] <= srcLevel ^ polarityInvert_reg[gi];
        end
      end
    end
  endgenerate

  assign digitalOutTtl = dout_reg[1:0];
  // open drain: a logical 1 switches the fet on and pulls the pin low
  assign openDrainOutputThreeOut = 1'b0;
  assign openDrainOutputThreeOe = dout_reg[2];
  assign openDrainOutputFourOut = 1'b0;
  assign openDrainOutputFourOe = dout_reg[3];

endmodule

// *** dv/adio_aux_io_assertions.sv ***
// port-level checker for the auxiliary digital i/o block
`timescale 1ns/1ns
module adio_aux_io_assertions (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic panelRelayReq,
  input wire logic contactClosed,
  input wire logic openDrainOutputThreeOut,
  input wire logic openDrainOutputFourOut,
  input wire logic strobeOut,
  input wire logic [2:0] riseEvent,
  input wire logic [2:0] fallEvent,
  input wire logic relayClose,
  input wire logic transientStart
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);

  pready_high_a: assert property (pready) else $error("pready low");
  err_access_a: assert property (pslverr |-> psel && penable) else $error("stray pslverr");
  unmapped_err_a: assert property (psel && penable && paddr > 8'h24 |-> pslverr)
    else $error("unmapped access not refused");
  od_level_a: assert property (!openDrainOutputThreeOut && !openDrainOutputFourOut)
    else $error("open-drain pin driven high");
  relay_open_a: assert property ((!panelRelayReq && !contactClosed)[*3] |=> !relayClose)
    else $error("relay closed without any request");
  relay_close_a: assert property ((panelRelayReq && contactClosed)[*4] |=> relayClose)
    else $error("relay open with panel and contact");
  strobe_width_a: assert property ($rose(strobeOut) |-> strobeOut[*8])
    else $error("strobe pulse too short");
  start_pulse_a: assert property (transientStart |=> !transientStart)
    else $error("transient start longer than one cycle");
  edge_excl_a: assert property ((riseEvent & fallEvent) == 3'h0)
    else $error("rise and fall on one channel");
  rise_pulse_a: assert property (|riseEvent |=> (riseEvent & $past(riseEvent)) == 3'h0)
    else $error("rise event longer than one cycle");

  cover property ($rose(strobeOut));
  cover property (transientStart);
  cover property (|fallEvent);
endmodule

// *** dv/adio_ext_equip.sv ***
// model of the external equipment: input pins, contact, trigger, pulled-up open-drain output pins
`timescale 1ns/1ns
module adio_ext_equip (
  input wire logic threeOe,
  input wire logic fourOe,
  output logic [2:0] digitalIn,
  output logic extTrigger,
  output logic contactClosed,
  output logic threePin,
  output logic fourPin
);
  initial begin
    digitalIn = 3'h0;
    extTrigger = 1'b0;
    contactClosed = 1'b0;
  end
  // internal pull-up wins whenever the fet is off
  assign threePin = threeOe ? 1'b0 : 1'b1;
  assign fourPin = fourOe ? 1'b0 : 1'b1;
  // called just after a clock edge; the contact is held until the next call
  task drive(input logic [2:0] d, input logic t, input logic c);
    digitalIn <= d;
    extTrigger <= t;
    contactClosed <= c;
  endtask
endmodule

// *** dv/tb.sv ***
// self-checking testbench for the auxiliary digital i/o block
`timescale 1ns/1ns
module tb;
  logic core_clk, nrst, psel, penable, pwrite, pready, pslverr, err, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic faultActive, singlePhase, programActive, remoteActive, transientActive;
  logic couplingModeFlag, panelRelayReq, runRequest, phaseUpdatePoint, settingChanged;
  logic [2:0] digitalIn, riseEvent, fallEvent;
  logic extTrigger, contactClosed, strobeOut, relayClose, transientStart, threePin, fourPin;
  logic [1:0] digitalOutTtl;
  logic openDrainOutputThreeOut, openDrainOutputThreeOe;
  logic openDrainOutputFourOut, openDrainOutputFourOe;
  int fails = 0;
  int total_checks = 0;
  int starts = 0;
  int n;
  logic [6:0] src;

  adio_aux_io #(.CYC_PER_MS(4)) adio_aux_io_i (.core_clk, .nrst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .faultActive, .singlePhase, .programActive,
    .remoteActive, .transientActive, .couplingModeFlag, .panelRelayReq, .runRequest,
    .phaseUpdatePoint, .settingChanged, .digitalIn, .extTrigger, .contactClosed,
    .digitalOutTtl, .openDrainOutputThreeOut, .openDrainOutputThreeOe,
    .openDrainOutputFourOut, .openDrainOutputFourOe, .strobeOut, .riseEvent, .fallEvent,
    .relayClose, .transientStart);
  adio_ext_equip adio_ext_equip_i (.threeOe(openDrainOutputThreeOe),
    .fourOe(openDrainOutputFourOe), .digitalIn, .extTrigger, .contactClosed, .threePin,
    .fourPin);

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  always @(posedge core_clk) if (transientStart === 1'b1) starts <= starts + 1;

  task cyc(input int k);
    repeat (k) @(posedge core_clk);
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // entered just after an edge; one idle cycle follows every transfer
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task strobe_len;
    n = 0;
    // sampled mid-cycle, away from the edge that moves the strobe
    repeat (40) begin
      @(negedge core_clk);
      if (strobeOut === 1'b1) n++;
    end
    @(posedge core_clk);
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    fails++;
    end_of_test;
  end

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {faultActive, singlePhase, programActive, remoteActive, transientActive} = '0;
    {couplingModeFlag, panelRelayReq, runRequest, phaseUpdatePoint, settingChanged} = '0;
    cyc(2);
    nrst <= 1'b1;
    cyc(2);
    apb(0, adio_pkg::OFS_DOUT_FUNC, 0);
    chk(rd, 32'h0);
    apb(0, 8'h28, 0);
    chk({rd[30:0], err}, 32'h1);
    $display("registers done");
    // ch1 and ch3 inverted
    apb(1, adio_pkg::OFS_DOUT_INV, 32'h5);
    for (int s = 0; s < 2; s++) for (int f = 0; f < 9; f++) begin
      apb(1, adio_pkg::OFS_DOUT_FUNC, {16'h0, {4{f[3:0]}}});
      // only the selected source differs from the others, so a mis-wired select shows
      src = (f < 2) ? 7'h00 : 7'(1 << (f - 2));
      {couplingModeFlag, transientActive, remoteActive, programActive, panelRelayReq,
        singlePhase, faultActive} <= s[0] ? src : ~src;
      cyc(5);
      e = (f == 0) ? 1'b0 : (f == 1) ? 1'b1 : s[0];
      chk({26'h0, digitalOutTtl, openDrainOutputThreeOe, openDrainOutputFourOe, threePin,
        fourPin}, {26'h0, e, ~e, ~e, e, e, ~e});
    end
    apb(0, adio_pkg::OFS_STATUS, 0);
    chk(rd, 32'h000000a0);
    $display("outputs done");
    for (int m = 0; m < 3; m++) for (int k = 0; k < 4; k++) begin
      apb(1, adio_pkg::OFS_REMOTE, m);
      panelRelayReq <= k[0];
      adio_ext_equip_i.drive(3'h0, 1'b0, k[1]);
      cyc(5);
      e = (m == 0) ? k[0] : (m == 1) ? (k[0] & k[1]) : (k[0] | k[1]);
      chk({31'h0, relayClose}, {31'h0, e});
    end
    apb(1, adio_pkg::OFS_REMOTE, 0);
    panelRelayReq <= 1'b0;
    adio_ext_equip_i.drive(3'h0, 1'b0, 1'b0);
    $display("relay done");
    apb(1, adio_pkg::OFS_FILT1, 2);
    apb(1, adio_pkg::OFS_EDGES, 32'h77);
    adio_ext_equip_i.drive(3'h1, 1'b0, 1'b0);
    cyc(4);
    adio_ext_equip_i.drive(3'h0, 1'b0, 1'b0);
    cyc(20);
    apb(0, adio_pkg::OFS_EDGES, 0);
    chk(rd, 32'h0);
    adio_ext_equip_i.drive(3'h1, 1'b0, 1'b0);
    cyc(20);
    adio_ext_equip_i.drive(3'h0, 1'b0, 1'b0);
    cyc(20);
    apb(0, adio_pkg::OFS_EDGES, 0);
    chk(rd, 32'h11);
    adio_ext_equip_i.drive(3'h2, 1'b0, 1'b0);
    cyc(3);
    adio_ext_equip_i.drive(3'h0, 1'b0, 1'b0);
    cyc(10);
    apb(0, adio_pkg::OFS_EDGES, 0);
    chk(rd, 32'h33);
    apb(1, adio_pkg::OFS_FILT3, 32'h00ffffff);
    apb(0, adio_pkg::OFS_FILT3, 0);
    chk(rd, adio_pkg::FILT_MAX_MS);
    $display("inputs done");
    apb(1, adio_pkg::OFS_STROBE, 4);
    cyc(30);
    settingChanged <= 1'b1;
    cyc(1);
    settingChanged <= 1'b0;
    strobe_len;
    chk(n, adio_pkg::STROBE_CYC);
    apb(1, adio_pkg::OFS_STROBE, 2);
    cyc(30);
    panelRelayReq <= 1'b1;
    strobe_len;
    chk(n, adio_pkg::STROBE_CYC);
    panelRelayReq <= 1'b0;
    apb(1, adio_pkg::OFS_STROBE, 1);
    cyc(30);
    $display("strobe done");
    // enable, immediate and auto-start all on
    apb(1, adio_pkg::OFS_TRIG, 7);
    adio_ext_equip_i.drive(3'h0, 1'b1, 1'b0);
    cyc(4);
    adio_ext_equip_i.drive(3'h0, 1'b0, 1'b0);
    strobe_len;
    chk(n, adio_pkg::STROBE_CYC);
    chk(starts, 1);
    apb(1, adio_pkg::OFS_TRIG, 1);
    runRequest <= 1'b1;
    cyc(1);
    runRequest <= 1'b0;
    adio_ext_equip_i.drive(3'h0, 1'b1, 1'b0);
    cyc(4);
    adio_ext_equip_i.drive(3'h0, 1'b0, 1'b0);
    cyc(10);
    chk(starts, 1);
    phaseUpdatePoint <= 1'b1;
    cyc(1);
    phaseUpdatePoint <= 1'b0;
    cyc(5);
    chk(starts, 2);
    // auto-start off: a trigger with no run request must not start anything
    adio_ext_equip_i.drive(3'h0, 1'b1, 1'b0);
    cyc(4);
    adio_ext_equip_i.drive(3'h0, 1'b0, 1'b0);
    cyc(10);
    chk(starts, 2);
    $display("trigger done");
    end_of_test;
  end
endmodule

bind adio_aux_io adio_aux_io_assertions adio_aux_io_assertions_i (.core_clk, .nrst, .psel,
  .penable, .paddr, .pready, .pslverr, .panelRelayReq, .contactClosed,
  .openDrainOutputThreeOut, .openDrainOutputFourOut, .strobeOut, .riseEvent, .fallEvent,
  .relayClose, .transientStart);
